// >>> logic/fts_pkg.sv
// constants and types for the fieldbus timeout supervisor
package fts_pkg;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_NS      = 10;
  localparam int TICK_MS     = 10;
  localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_NS;
  localparam int TMO_MIN_MS  = 50;
  localparam int TMO_MAX_S   = 18000;
  localparam int TMO_DEF_MS  = 1000;
  localparam logic [20:0] TMO_MIN = 21'(TMO_MIN_MS / TICK_MS);
  localparam logic [20:0] TMO_MAX = 21'(TMO_MAX_S * 1000 / TICK_MS);
  localparam logic [20:0] TMO_DEF = 21'(TMO_DEF_MS / TICK_MS);
  // -----------------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TMO    = 8'h04;
  localparam logic [7:0] ADDR_RESP   = 8'h08;
  localparam logic [7:0] ADDR_STAT   = 8'h0c;
  localparam logic [7:0] ADDR_MASK   = 8'h10;
  localparam logic [7:0] ADDR_STATE  = 8'h14;
  localparam logic [7:0] ADDR_LOGIDX = 8'h18;
  localparam logic [7:0] ADDR_LOGDAT = 8'h1c;
  localparam logic [7:0] ADDR_PDATA  = 8'h20;
  localparam logic [7:0] ADDR_SPEED  = 8'h24;
  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int CTRL_PROFILE = 0;
  localparam int CTRL_RESET   = 1;
  localparam int RESP_PD      = 0;
  localparam int RESP_FB      = 4;
  localparam int RESP_NC      = 8;
  localparam int RESP_ALT     = 12;
  localparam int RESP_HOME    = 16;
  localparam int ST_TMO       = 0;
  localparam int ST_FBF       = 1;
  localparam int ST_NOC       = 2;
  localparam int ST_FLT       = 3;
  localparam int STAT_W       = 4;
  localparam int CW_RUN       = 0;
  localparam int CW_ENOP      = 3;
  localparam int CW_ACK       = 7;
  localparam int SW_READY     = 0;
  localparam int SW_RUN       = 1;
  localparam int SW_OPEN      = 2;
  localparam int SW_FAULT     = 3;
  localparam int SW_WARN      = 7;
  localparam int SW_REMOTE    = 9;
  // -----------------------------------------------------------------
  // reference scaling and log
  // -----------------------------------------------------------------
  localparam logic [15:0] REF_ZERO     = 16'h0000;
  localparam logic [15:0] REF_PLUS100  = 16'h4000;
  localparam logic [15:0] REF_MINUS100 = 16'hc000;
  localparam int          REF_SHIFT    = 14;
  localparam logic [15:0] PCT_SCALE    = 16'h2710;
  localparam int          LOG_AW       = 4;
  localparam logic [2:0]  LOG_INFO     = 3'h2;
  localparam logic [2:0]  LOG_WARN     = 3'h3;
  localparam logic [2:0]  LOG_FAULT    = 3'h4;
  localparam logic [7:0]  EVC_TMO      = 8'h01;
  localparam logic [7:0]  EVC_FBF      = 8'h02;
  localparam logic [7:0]  EVC_NOC      = 8'h03;
  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [0:0] {PROF_NATIVE = 1'h0, PROF_STD = 1'h1} fts_profile_t;
  typedef enum logic [2:0] {
    PD_LOG = 3'h0, PD_WARN = 3'h1, PD_WARN_SW = 3'h2,
    PD_WARN_SWP = 3'h3, PD_FLT_RAMP = 3'h4, PD_FLT = 3'h5
  } fts_pdresp_t;
  typedef enum logic [1:0] {
    EV_LOG = 2'h0, EV_WARN = 2'h1, EV_FLT_RAMP = 2'h2, EV_FLT_COAST = 2'h3
  } fts_evresp_t;
  typedef enum logic [1:0] {
    PLACE_LOCAL = 2'h0, PLACE_FIELDBUS = 2'h1, PLACE_IO = 2'h2, PLACE_ADV = 2'h3
  } fts_place_t;
  typedef enum logic [2:0] {PL_HOME = 3'b001, PL_ALT = 3'b010, PL_HELD = 3'b100} fts_plstate_t;
  localparam fts_profile_t PROFILE_RST = PROF_NATIVE;
  localparam fts_pdresp_t  PD_RESP_RST = PD_FLT;
  localparam fts_evresp_t  FB_RESP_RST = EV_LOG;
  localparam fts_evresp_t  NC_RESP_RST = EV_LOG;
  localparam fts_place_t   ALT_RST     = PLACE_LOCAL;
  localparam fts_place_t   HOME_RST    = PLACE_FIELDBUS;
endpackage

// >>> logic/fts_log_mem.sv
// event log memory with registered read data
`timescale 1ns/1ps
module fts_log_mem
  import fts_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              wrEn,
  input  wire logic [LOG_AW-1:0] wrAddr,
  input  wire logic [15:0]       wrData,
  input  wire logic [LOG_AW-1:0] rdAddr,
  output logic      [15:0]       rdData
);
  logic [15:0] mem [0:(1<<LOG_AW)-1];

  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // unwritten entries read as unknown until the log wraps once
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= 16'h0000;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule

// >>> logic/fts_supervisor.sv
// fieldbus process-data timeout supervisor, top level
`timescale 1ns/1ps
module fts_supervisor #(
  parameter int TICK_CYC = fts_pkg::TICK_CYCLES
) (
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  input  wire logic [7:0]          regAddr,
  input  wire logic [31:0]         regWdata,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic      [31:0]         regRdata,
  input  wire logic                pdValid,
  input  wire logic [15:0]         pdCtrlWord,
  input  wire logic [15:0]         pdRef,
  input  wire logic                fbFaultPin,
  input  wire logic                fbLinkPin,
  input  wire logic                rampDone,
  output logic                     warning,
  output logic                     fault,
  output logic                     rampStop,
  output logic                     coast,
  output logic                     runCmd,
  output fts_pkg::fts_place_t      controlPlace,
  output logic      [15:0]         statusWord,
  output logic      [15:0]         speedPct,
  output logic                     irq
);
  import fts_pkg::*;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic evFault(input fts_evresp_t r);
    return (r == EV_FLT_RAMP) || (r == EV_FLT_COAST);
  endfunction

  function automatic logic [2:0] evType(input logic isWarn, input logic isFlt);
    return isFlt ? LOG_FAULT : (isWarn ? LOG_WARN : LOG_INFO);
  endfunction

  // out-of-range settings are pulled to the nearest legal value
  function automatic logic [20:0] clampTmo(input logic [31:0] v);
    if (v < 32'(TMO_MIN)) return TMO_MIN;
    if (v > 32'(TMO_MAX)) return TMO_MAX;
    return v[20:0];
  endfunction

  // hundredths of a percent: 4000 hex gives 10000
  function automatic logic [15:0] pct(input logic [15:0] r);
    logic signed [31:0] p;
    p = $signed(r) * $signed({16'h0000, PCT_SCALE});
    return 16'(p >>> REF_SHIFT);
  endfunction

  // -----------------------------------------------------------------
  // registers and state
  // -----------------------------------------------------------------
  fts_profile_t     profile;
  logic [20:0]      tmoSet;
  fts_pdresp_t      pdResp;
  fts_evresp_t      fbResp, ncResp;
  fts_place_t       altPlace, homePlace;
  logic [STAT_W-1:0] stat, mask;
  logic [LOG_AW-1:0] logIdx, logWrPtr;
  logic [19:0]      tickCnt;
  logic [20:0]      gapTicks;
  logic             tmoActive;
  logic [2:0]       fbSync, lkSync;
  logic             fbF, lkF, fbFd, lkFd;
  logic             faultRamp;
  logic [15:0]      ctrlWord, refHeld;
  fts_plstate_t     plState, next_plState;
  logic [15:0]      logRdData;

  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  wire wrCtrl   = regWr && regAddr == ADDR_CTRL;
  wire wrTmo    = regWr && regAddr == ADDR_TMO;
  wire wrResp   = regWr && regAddr == ADDR_RESP;
  wire wrStat   = regWr && regAddr == ADDR_STAT;
  wire wrMask   = regWr && regAddr == ADDR_MASK;
  wire wrLogIdx = regWr && regAddr == ADDR_LOGIDX;
  wire ackCmd   = (wrCtrl && regWdata[CTRL_RESET]) || (pdValid && pdCtrlWord[CW_ACK]);
  wire noConn   = !lkF;
  wire tickEnd  = tickCnt == 20'(TICK_CYC - 1);
  wire [20:0] gapNext = gapTicks + 21'h000001;
  wire tmoHit   = tickEnd && !tmoActive && !pdValid && gapNext >= tmoSet;
  wire fbRise   = fbF && !fbFd;
  wire ncRise   = noConn && lkFd;
  wire pdIsWarn = pdResp == PD_WARN || pdResp == PD_WARN_SW || pdResp == PD_WARN_SWP;
  wire pdIsFlt  = pdResp == PD_FLT || pdResp == PD_FLT_RAMP;
  wire pdIsSw   = pdResp == PD_WARN_SW || pdResp == PD_WARN_SWP;
  wire fbIsWarn = fbResp == EV_WARN;
  wire ncIsWarn = ncResp == EV_WARN;
  wire rampTrip = (tmoHit && pdResp == PD_FLT_RAMP) || (fbRise && fbResp == EV_FLT_RAMP)
               || (ncRise && ncResp == EV_FLT_RAMP);
  wire faultTrip = (tmoHit && pdIsFlt) || (fbRise && evFault(fbResp))
                || (ncRise && evFault(ncResp));
  // a log-only source drives neither term
  wire warnNow  = (tmoActive && pdIsWarn) || (fbF && fbIsWarn)
               || (noConn && ncIsWarn);
  wire next_fault     = faultTrip || (fault && !ackCmd);
  wire next_faultRamp = rampTrip || (faultRamp && !faultTrip && next_fault);
  wire next_rampStop  = next_fault && next_faultRamp && !rampDone;
  wire next_coast     = next_fault && (!next_faultRamp || rampDone);
  wire [15:0] next_ctrl = pdValid ? pdCtrlWord : ctrlWord;
  wire [15:0] next_ref  = pdValid ? pdRef : refHeld;
  wire remote   = controlPlace == PLACE_FIELDBUS || controlPlace == PLACE_ADV;
  wire runBits  = (profile == PROF_NATIVE) ? next_ctrl[CW_RUN]
               : (next_ctrl[CW_RUN] && next_ctrl[CW_ENOP]);
  wire next_run = runBits && remote && !next_fault;
  wire [STAT_W-1:0] evSet = {faultTrip, ncRise, fbRise, tmoHit};
  wire [STAT_W-1:0] next_stat = (stat & ~(wrStat ? regWdata[STAT_W-1:0] : '0)) | evSet;
  // simultaneous onsets log only the highest priority one
  wire logWe    = tmoHit || fbRise || ncRise;
  wire [15:0] logEntry = tmoHit ? {1'b1, evType(pdIsWarn, pdIsFlt), 4'h0, EVC_TMO}
                     : fbRise ? {1'b1, evType(fbIsWarn, evFault(fbResp)), 4'h0, EVC_FBF}
                              : {1'b1, evType(ncIsWarn, evFault(ncResp)), 4'h0, EVC_NOC};
  wire fts_place_t next_place = (next_plState == PL_HOME) ? homePlace : altPlace;
  wire [15:0] swNative = 16'((1 << SW_READY) | (32'(next_run) << SW_RUN)
                       | (32'(next_fault) << SW_FAULT) | (32'(warnNow) << SW_WARN));
  wire [15:0] swStd = 16'((32'(!next_fault) << SW_READY) | (32'(next_run) << SW_OPEN)
                    | (32'(next_fault) << SW_FAULT) | (32'(warnNow) << SW_WARN)
                    | (32'(remote) << SW_REMOTE));
  wire [31:0] stateWord = {21'h000000, logWrPtr, plState, faultRamp, tmoActive, noConn, fbF};
  wire [31:0] rdMux =
      regAddr == ADDR_CTRL   ? {31'h00000000, profile} :
      regAddr == ADDR_TMO    ? {11'h000, tmoSet} :
      regAddr == ADDR_RESP   ? {14'h0000, homePlace, 2'h0, altPlace, 2'h0, ncResp,
                                2'h0, fbResp, 1'h0, pdResp} :
      regAddr == ADDR_STAT   ? {28'h0000000, stat} :
      regAddr == ADDR_MASK   ? {28'h0000000, mask} :
      regAddr == ADDR_STATE  ? stateWord :
      regAddr == ADDR_LOGIDX ? {28'h0000000, logIdx} :
      regAddr == ADDR_LOGDAT ? {16'h0000, logRdData} :
      regAddr == ADDR_PDATA  ? {refHeld, ctrlWord} :
      regAddr == ADDR_SPEED  ? {16'h0000, speedPct} : 32'h00000000;

  // -----------------------------------------------------------------
  // register file
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      profile   <= PROFILE_RST;
      tmoSet    <= TMO_DEF;
      pdResp    <= PD_RESP_RST;
      fbResp    <= FB_RESP_RST;
      ncResp    <= NC_RESP_RST;
      altPlace  <= ALT_RST;
      homePlace <= HOME_RST;
      mask      <= '0;
      logIdx    <= '0;
    end else begin
      if (wrCtrl) profile <= fts_profile_t'(regWdata[CTRL_PROFILE]);
      if (wrTmo) tmoSet <= clampTmo(regWdata);
      if (wrResp) begin
        // codes 6 and 7 are not defined; they fall back to the safest response
        pdResp    <= (regWdata[RESP_PD+:3] > 3'h5) ? PD_FLT
                   : fts_pdresp_t'(regWdata[RESP_PD+:3]);
        fbResp    <= fts_evresp_t'(regWdata[RESP_FB+:2]);
        ncResp    <= fts_evresp_t'(regWdata[RESP_NC+:2]);
        altPlace  <= fts_place_t'(regWdata[RESP_ALT+:2]);
        homePlace <= fts_place_t'(regWdata[RESP_HOME+:2]);
      end
      if (wrMask) mask <= regWdata[STAT_W-1:0];
      if (wrLogIdx) logIdx <= regWdata[LOG_AW-1:0];
    end
  end

  // -----------------------------------------------------------------
  // input synchronisers, change accepted when stages two and three agree
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fbSync <= 3'h0;
      lkSync <= 3'h0;
      fbF    <= 1'b0;
      lkF    <= 1'b0;
      fbFd   <= 1'b0;
      lkFd   <= 1'b0;
    end else begin
      fbSync <= {fbSync[1:0], fbFaultPin};
      lkSync <= {lkSync[1:0], fbLinkPin};
      if (fbSync[1] == fbSync[2]) fbF <= fbSync[2];
      if (lkSync[1] == lkSync[2]) lkF <= lkSync[2];
      fbFd   <= fbF;
      lkFd   <= lkF;
    end
  end

  // -----------------------------------------------------------------
  // timeout timer
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt   <= '0;
      gapTicks  <= '0;
      tmoActive <= 1'b0;
    end else if (pdValid) begin
      tickCnt   <= '0;
      gapTicks  <= '0;
      tmoActive <= 1'b0;
    end else begin
      tickCnt <= tickEnd ? '0 : tickCnt + 20'h00001;
      if (tickEnd && !tmoActive) gapTicks <= gapNext;
      if (tmoHit) tmoActive <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // control place
  // -----------------------------------------------------------------
  always_comb begin
    next_plState = plState;
    unique case (plState)
      PL_HOME: if (tmoHit && pdIsSw) begin
        next_plState = (pdResp == PD_WARN_SWP) ? PL_HELD : PL_ALT;
      end
      PL_ALT:  if (!tmoActive || pdValid) next_plState = PL_HOME;
      PL_HELD: if (ackCmd && (!tmoActive || pdValid)) next_plState = PL_HOME;
      default: next_plState = PL_HOME;
    endcase
  end

  // -----------------------------------------------------------------
  // responses and outputs
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      plState      <= PL_HOME;
      controlPlace <= HOME_RST;
      fault        <= 1'b0;
      faultRamp    <= 1'b0;
      rampStop     <= 1'b0;
      coast        <= 1'b0;
      warning      <= 1'b0;
      runCmd       <= 1'b0;
      ctrlWord     <= 16'h0000;
      refHeld      <= REF_ZERO;
      speedPct     <= 16'h0000;
      statusWord   <= 16'h0000;
      stat         <= '0;
      irq          <= 1'b0;
      logWrPtr     <= '0;
      regRdata     <= 32'h00000000;
    end else begin
      plState      <= next_plState;
      controlPlace <= next_place;
      fault        <= next_fault;
      faultRamp    <= next_faultRamp;
      rampStop     <= next_rampStop;
      coast        <= next_coast;
      warning      <= warnNow;
      runCmd       <= next_run;
      ctrlWord     <= next_ctrl;
      refHeld      <= next_ref;
      speedPct     <= pct(next_ref);
      statusWord   <= (profile == PROF_NATIVE) ? swNative : swStd;
      stat         <= next_stat;
      irq          <= |(next_stat & mask);
      if (logWe) logWrPtr <= logWrPtr + 4'h1;
      regRdata     <= regRd ? rdMux : 32'h00000000;
    end
  end

  fts_log_mem u_log (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .wrEn    (logWe),
    .wrAddr  (logWrPtr),
    .wrData  (logEntry),
    .rdAddr  (logIdx),
    .rdData  (logRdData)
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  data_clears_tmo_a: assert property (pdValid |=> !tmoActive && gapTicks == 21'h0)
    else $error("timeout not cleared by process data");
  tmo_onset_a: assert property (tmoHit |=> tmoActive && stat[ST_TMO])
    else $error("timeout onset not recorded");
  coast_fault_a: assert property (fault && !faultRamp |-> coast && !rampStop)
    else $error("plain fault did not coast");
  ramp_first_a: assert property ($rose(fault) && faultRamp && !$past(rampDone)
    |-> rampStop && !coast)
    else $error("ramp fault did not ramp first");
  log_entry_a: assert property (tmoHit |=> logWrPtr == $past(logWrPtr) + 4'h1)
    else $error("timeout not logged");
  alt_place_a: assert property (plState == PL_ALT && $stable(altPlace)
    |-> controlPlace == altPlace)
    else $error("alternate place not applied");
  held_place_a: assert property (plState == PL_HELD && !ackCmd |=> plState == PL_HELD)
    else $error("persistent place left without reset");
  warn_level_a: assert property (tmoActive && pdIsWarn |=> warning)
    else $error("warning missing during timeout");
  ref_scale_a: assert property (pdValid && pdRef == REF_PLUS100
    |=> speedPct == PCT_SCALE)
    else $error("full scale reference misread");

  tmo_seen_c: cover property (tmoHit);
  held_seen_c: cover property (plState == PL_HELD ##1 plState == PL_HOME);
  ramp_coast_c: cover property (rampStop ##[1:50] coast && faultRamp);
endmodule

// >>> test/fts_ctrl_model.sv
// remote controller model that sends cyclic process data after a chosen lag
`timescale 1ns/1ps
module fts_ctrl_model (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        sendReq,
  input  wire logic [1:0]  lag,
  input  wire logic [15:0] ctrlIn,
  input  wire logic [15:0] refIn,
  output logic             pdValid,
  output logic      [15:0] pdCtrlWord,
  output logic      [15:0] pdRef
);
  logic [1:0]  cnt;
  logic        pend;
  logic [31:0] held;
  // idle data lines toggle each cycle so a stale word never looks valid
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pend <= 1'b0;
      cnt <= 2'h0;
      held <= 32'h0;
      pdValid <= 1'b0;
      {pdRef, pdCtrlWord} <= 32'h0;
    end else begin
      pdValid <= 1'b0;
      {pdRef, pdCtrlWord} <= ~{pdRef, pdCtrlWord};
      if (sendReq) begin
        pend <= 1'b1;
        cnt <= lag;
        held <= {refIn, ctrlIn};
      end else if (pend && cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end else if (pend) begin
        pend <= 1'b0;
        pdValid <= 1'b1;
        {pdRef, pdCtrlWord} <= held;
      end
    end
  end
endmodule

// >>> test/tb.sv
// self-checking bench for the fieldbus timeout supervisor
`timescale 1ns/1ps
module tb;
  import fts_pkg::*;
  logic        ref_clk = 0, rstn = 0, regWr = 0, regRd = 0, sendReq = 0;
  logic        fbFaultPin = 0, fbLinkPin = 0, rampDone = 0;
  logic [7:0]  regAddr = 8'h00;
  logic [1:0]  lag = 2'h0;
  logic [31:0] regWdata = 32'h0, regRdata, rv;
  logic [15:0] cIn = 16'h0, rIn = 16'h0, pdCtrlWord, pdRef, statusWord, speedPct;
  logic        pdValid, warning, fault, rampStop, coast, runCmd, irq;
  fts_place_t  controlPlace;
  int          n_mismatch = 0, samples_checked = 0, cyc = 0, k;
  always #5 ref_clk = ~ref_clk;
  fts_ctrl_model i_ctrl (.ref_clk, .rstn, .sendReq, .lag, .ctrlIn(cIn), .refIn(rIn),
    .pdValid, .pdCtrlWord, .pdRef);
  fts_supervisor #(.TICK_CYC(10)) i_dut (.ref_clk, .rstn, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .pdValid, .pdCtrlWord, .pdRef, .fbFaultPin, .fbLinkPin, .rampDone,
    .warning, .fault, .rampStop, .coast, .runCmd, .controlPlace, .statusWord, .speedPct, .irq);
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    regWr <= 1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regRd <= 1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 0;
    #1 d = regRdata;
  endtask
  task settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // lag is random, so the wait follows the model's own strobe
  task automatic pd(logic [15:0] c, logic [15:0] r);
    @(posedge ref_clk);
    sendReq <= 1;
    cIn <= c;
    rIn <= r;
    lag <= 2'($urandom);
    @(posedge ref_clk);
    sendReq <= 0;
    repeat (8) if (pdValid !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    settle();
  endtask
  // expected outputs from response code, timeout state, latched fault, held place
  task automatic chk(int r, bit tmo, bit flt, bit per);
    cmp("warning", 32'(tmo && r inside {[1:3]}), warning);
    cmp("fault", 32'(flt), fault);
    cmp("rampStop", 32'(flt && r == 4 && !rampDone), rampStop);
    cmp("coast", 32'(flt && (r == 5 || rampDone)), coast);
    cmp("place", ((tmo && r inside {2, 3}) || per) ? 32'h2 : 32'h1, controlPlace);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h5755));
    repeat (3) @(posedge ref_clk);
    rstn <= 1;
    rd(ADDR_TMO, rv);
    cmp("timeout", 32'h64, rv);
    rd(ADDR_RESP, rv);
    cmp("resp", 32'h10005, rv);
    rd(8'h30, rv);
    cmp("unmapped", 32'h0, rv);
    cmp("place", 32'h1, controlPlace);
    $display("test reset values done");
    for (k = -16; k <= 16; k++) begin
      pd({12'h0, 1'($urandom), 3'h1}, 16'(k * 1024));
      cmp("speedPct", {16'h0000, 16'(k * 625)}, speedPct);
      cmp("runCmd", 32'h1, runCmd);
      cmp("statusWord", 32'h3, statusWord);
    end
    wr(ADDR_CTRL, 32'h1);
    pd(16'h0001, 16'h0);
    cmp("runCmd", 32'h0, runCmd);
    cmp("statusWord", 32'h201, statusWord);
    pd(16'h0009, 16'h0);
    cmp("runCmd", 32'h1, runCmd);
    cmp("statusWord", 32'h205, statusWord);
    $display("test reference and profile done");
    wr(ADDR_RESP, 32'h10030);
    wr(ADDR_MASK, 32'h2);
    @(posedge ref_clk) fbFaultPin <= 1;
    repeat (10) @(posedge ref_clk);
    #1;
    cmp("fault", 32'h1, fault);
    cmp("coast", 32'h1, coast);
    cmp("irq", 32'h1, irq);
    wr(ADDR_STAT, 32'h2);
    settle();
    cmp("irq", 32'h0, irq);
    @(posedge ref_clk) fbFaultPin <= 0;
    wr(ADDR_CTRL, 32'h2);
    settle();
    cmp("fault", 32'h0, fault);
    wr(ADDR_RESP, 32'h10100);
    @(posedge ref_clk) fbLinkPin <= 1;
    repeat (10) @(posedge ref_clk);
    fbLinkPin <= 0;
    repeat (10) @(posedge ref_clk);
    #1;
    cmp("warning", 32'h1, warning);
    rd(ADDR_STAT, rv);
    cmp("stat", 32'h4, rv & 32'h4);
    @(posedge ref_clk) fbLinkPin <= 1;
    repeat (10) @(posedge ref_clk);
    // lost connection with the ramp response: ramp first, no coast until the ramp ends
    wr(ADDR_RESP, 32'h10200);
    fbLinkPin <= 0;
    repeat (10) @(posedge ref_clk);
    #1;
    cmp("fault", 32'h1, fault);
    cmp("rampStop", 32'h1, rampStop);
    cmp("coast", 32'h0, coast);
    @(posedge ref_clk) fbLinkPin <= 1;
    wr(ADDR_CTRL, 32'h2);
    settle();
    cmp("fault", 32'h0, fault);
    $display("test fieldbus events done");
    wr(ADDR_TMO, 32'h0);
    rd(ADDR_TMO, rv);
    cmp("timeout", 32'h5, rv);
    for (int r = 0; r < 6; r++) begin
      wr(ADDR_STAT, 32'hf);
      wr(ADDR_RESP, 32'h12000 | r);
      pd(16'h0, 16'h0);
      repeat (60) @(posedge ref_clk);
      #1;
      chk(r, 1, r > 3, 0);
      rd(ADDR_STAT, rv);
      cmp("stat", (r > 3) ? 32'h9 : 32'h1, rv & 32'h9);
      // newest log entry sits one below the write pointer
      rd(ADDR_STATE, rv);
      wr(ADDR_LOGIDX, ((rv >> 7) - 32'h1) & 32'hf);
      rd(ADDR_LOGDAT, rv);
      cmp("logEntry", (r > 3) ? 32'hc001 : ((r > 0) ? 32'hb001 : 32'ha001), rv);
      if (r == 4) begin
        @(posedge ref_clk) rampDone <= 1;
        settle();
        chk(r, 1, 1, 0);
      end
      pd(16'h0, 16'h0);
      chk(r, 0, r > 3, r == 3);
      wr(ADDR_CTRL, 32'h2);
      settle();
      chk(r, 0, 0, 0);
      @(posedge ref_clk) rampDone <= 0;
    end
    wr(ADDR_RESP, 32'h7);
    rd(ADDR_RESP, rv);
    cmp("resp", 32'h5, rv);
    $display("test timeout responses done");
    end_sim();
  end
endmodule
